// [hdl/oepc_pkg.sv]
// Shared constants and timing counts for the one-time-programmable memory programmer
package oepc_pkg;

    // System clock
    localparam int CLK_PERIOD_NS = 40;

    // Pin widths of the memory and width of the interval timer
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int TMR_W  = 12;

    // Least time rounded up to whole cycles, never below one
    function automatic int cyc_min(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_min

    // Longest time rounded down to whole cycles, never below one
    function automatic int cyc_max(input int t_ns);
        int c;
        c = t_ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_max

    // Times as printed, in ns
    localparam int T_SETUP_NS      = 2000;   // Address, data, supply and margin setups and holds
    localparam int T_A10_NS        = 1000;   // Margin-select settle and hold around chip select
    localparam int T_PULSE_NS      = 100000; // Program pulse
    localparam int T_PULSE_MIN_NS  = 95000;
    localparam int T_PULSE_MAX_NS  = 105000;
    localparam int T_DV_NS         = 1000;   // Chip select low to verify data valid
    localparam int T_MARGIN_PW_NS  = 2000;   // Chip select pulse that latches the margin setting
    localparam int T_TURN_NS       = 200;    // Data bus turnaround after the memory lets go (130 ns)

    // Counts in cycles
    localparam logic [TMR_W-1:0] CYC_SETUP     = TMR_W'(cyc_min(T_SETUP_NS));
    localparam logic [TMR_W-1:0] CYC_A10       = TMR_W'(cyc_min(T_A10_NS));
    localparam logic [TMR_W-1:0] CYC_PULSE     = TMR_W'(cyc_min(T_PULSE_NS));
    localparam logic [TMR_W-1:0] CYC_PULSE_MIN = TMR_W'(cyc_min(T_PULSE_MIN_NS));
    localparam logic [TMR_W-1:0] CYC_PULSE_MAX = TMR_W'(cyc_max(T_PULSE_MAX_NS));
    localparam logic [TMR_W-1:0] CYC_DV        = TMR_W'(cyc_min(T_DV_NS) + 1);
    localparam logic [TMR_W-1:0] CYC_MARGIN_PW = TMR_W'(cyc_min(T_MARGIN_PW_NS));
    localparam logic [TMR_W-1:0] CYC_TURN      = TMR_W'(cyc_min(T_TURN_NS));

    // Pulse budget per byte before the byte is given up
    localparam logic [7:0] MAX_PULSES = 8'h19;

    // Address bit positions with special meaning
    localparam int MARGIN_SEL_BIT = 10;
    localparam int ID_HV_BIT      = 9;

    // Command codes
    localparam logic [2:0] OP_READ         = 3'h0;
    localparam logic [2:0] OP_PROGRAM      = 3'h1;
    localparam logic [2:0] OP_READ_ID      = 3'h2;
    localparam logic [2:0] OP_MARGIN_SET   = 3'h3;
    localparam logic [2:0] OP_MARGIN_CLEAR = 3'h4;

    // Reset values of the pins
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

endpackage : oepc_pkg

// [hdl/oepc_timer.sv]
// Down-counting interval timer used to pace every pin edge of the programmer except those set when a command is taken
`timescale 1ns/10ps
module oepc_timer (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       start_i,
    input  wire logic [oepc_pkg::TMR_W-1:0] load_i,
    output logic                            done_o
);

    logic [oepc_pkg::TMR_W-1:0] cnt_ff;
    logic                       run_ff;

    // Done is high in the last of load_i cycles after the start
    assign done_o = run_ff && (cnt_ff == '0);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
        end else if (start_i) begin
            cnt_ff <= load_i - oepc_pkg::TMR_W'(1);
            run_ff <= 1'b1;
        end else if (run_ff) begin
            if (cnt_ff == '0) begin
                run_ff <= 1'b0;
            end else begin
                cnt_ff <= cnt_ff - oepc_pkg::TMR_W'(1);
            end
        end
    end

endmodule : oepc_timer

// [hdl/oepc_ctrl.sv]
// Programmer controller that drives a 64K x 8 one-time-programmable memory through its pins
`timescale 1ns/10ps
module oepc_ctrl (
    input  wire logic                        MCLK_I,
    input  wire logic                        RESET_N_I,
    // User command port
    input  wire logic                        CMD_VALID_I,
    input  wire logic [2:0]                  CMD_OP_I,
    input  wire logic [oepc_pkg::ADDR_W-1:0] CMD_ADDR_I,
    input  wire logic [oepc_pkg::DATA_W-1:0] CMD_DATA_I,
    output logic                             CMD_READY_O,
    output logic                             RSP_VALID_O,
    output logic [oepc_pkg::DATA_W-1:0]      RSP_DATA_O,
    output logic                             RSP_FAIL_O,
    output logic [7:0]                       RSP_PULSES_O,
    output logic                             MARGIN_ACTIVE_O,
    // Memory pins
    output logic [oepc_pkg::ADDR_W-1:0]      MEM_ADDR_O,
    output logic                             MEM_ID_HIGH_VOLTAGE_EN_O,
    output logic                             MEM_CHIP_SEL_N_O,
    output logic                             MEM_OUTPUT_GATE_N_O,
    output logic                             MEM_PROGRAM_SUPPLY_EN_O,
    input  wire logic [oepc_pkg::DATA_W-1:0] MEM_DATA_PINS_I,
    output logic [oepc_pkg::DATA_W-1:0]      MEM_DATA_PINS_O,
    output logic                             MEM_DATA_PINS_OE_O
);

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_MG_HV_UP,
        ST_MG_SUPPLY_UP,
        ST_MG_PULSE,
        ST_MG_HOLD,
        ST_MG_SUPPLY_DOWN,
        ST_PG_SETUP,
        ST_PG_PULSE,
        ST_PG_HOLD,
        ST_VF_SETUP,
        ST_VF_ACCESS,
        ST_TURN
    } oepc_state_e;

    oepc_state_e                  state_ff;
    logic [2:0]                   op_ff;
    logic [oepc_pkg::ADDR_W-1:0]  addr_ff;
    logic [oepc_pkg::DATA_W-1:0]  data_ff;
    logic [oepc_pkg::DATA_W-1:0]  rd_ff;
    logic [7:0]                   pulses_ff;
    logic                         margin_ff;
    logic                         margin_tgt_ff;
    logic                         prog_pend_ff;
    logic                         fin_ff;
    logic                         fin_fail_ff;
    logic                         retry_ff;
    logic                         tmr_start_ff;
    logic [oepc_pkg::TMR_W-1:0]   tmr_load_ff;
    logic                         tmr_done;

    logic                         ready_ff;
    logic                         rsp_valid_ff;
    logic [oepc_pkg::DATA_W-1:0]  rsp_data_ff;
    logic                         rsp_fail_ff;
    logic [oepc_pkg::ADDR_W-1:0]  mem_addr_ff;
    logic                         id_hv_ff;
    logic                         cs_n_ff;
    logic                         gate_n_ff;
    logic                         supply_ff;
    logic [oepc_pkg::DATA_W-1:0]  dout_ff;
    logic                         doe_ff;

    // A zero in the memory where a one is wanted can never be repaired by more pulses
    function automatic logic unrepairable(input logic [7:0] rd, input logic [7:0] want);
        return ((~rd & want) != 8'h00);
    endfunction : unrepairable

    oepc_timer u_timer (
        .clk_i   (MCLK_I),
        .rst_n_i (RESET_N_I),
        .start_i (tmr_start_ff),
        .load_i  (tmr_load_ff),
        .done_o  (tmr_done)
    );

    // Sequencer: every pin edge after those set when the command is taken waits until the previous interval has run out
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_ff      <= ST_IDLE;
            op_ff         <= oepc_pkg::OP_READ;
            addr_ff       <= oepc_pkg::ADDR_RST;
            data_ff       <= oepc_pkg::DATA_RST;
            rd_ff         <= oepc_pkg::DATA_RST;
            pulses_ff     <= 8'h00;
            margin_tgt_ff <= 1'b0;
            prog_pend_ff  <= 1'b0;
            fin_ff        <= 1'b0;
            fin_fail_ff   <= 1'b0;
            retry_ff      <= 1'b0;
            tmr_start_ff  <= 1'b0;
            tmr_load_ff   <= '0;
            mem_addr_ff   <= oepc_pkg::ADDR_RST;
            id_hv_ff      <= 1'b0;
            cs_n_ff       <= 1'b1;
            gate_n_ff     <= 1'b1;
            supply_ff     <= 1'b0;
            dout_ff       <= oepc_pkg::DATA_RST;
            doe_ff        <= 1'b0;
        end else begin
            tmr_start_ff <= 1'b0;
            fin_ff       <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (CMD_VALID_I && ready_ff) begin
                        op_ff        <= CMD_OP_I;
                        addr_ff      <= CMD_ADDR_I;
                        data_ff      <= CMD_DATA_I;
                        pulses_ff    <= 8'h00;
                        prog_pend_ff <= 1'b0;
                        tmr_start_ff <= 1'b1;
                        tmr_load_ff  <= oepc_pkg::CYC_SETUP;
                        case (CMD_OP_I)
                            oepc_pkg::OP_READ: begin
                                mem_addr_ff <= CMD_ADDR_I;
                                state_ff    <= ST_VF_SETUP;
                            end
                            oepc_pkg::OP_READ_ID: begin
                                mem_addr_ff <= {15'h0000, CMD_ADDR_I[0]};
                                id_hv_ff    <= 1'b1;
                                state_ff    <= ST_VF_SETUP;
                            end
                            oepc_pkg::OP_PROGRAM: begin
                                if (margin_ff) begin
                                    state_ff    <= ST_PG_SETUP;
                                    mem_addr_ff <= CMD_ADDR_I;
                                    dout_ff     <= CMD_DATA_I;
                                    doe_ff      <= 1'b1;
                                    supply_ff   <= 1'b1;
                                end else begin
                                    // Margin is set first so no pulse lands without it
                                    prog_pend_ff  <= 1'b1;
                                    margin_tgt_ff <= 1'b1;
                                    mem_addr_ff[oepc_pkg::MARGIN_SEL_BIT] <= 1'b1;
                                    id_hv_ff      <= 1'b1;
                                    state_ff      <= ST_MG_HV_UP;
                                end
                            end
                            oepc_pkg::OP_MARGIN_SET, oepc_pkg::OP_MARGIN_CLEAR: begin
                                margin_tgt_ff <= (CMD_OP_I == oepc_pkg::OP_MARGIN_SET);
                                mem_addr_ff[oepc_pkg::MARGIN_SEL_BIT] <= (CMD_OP_I == oepc_pkg::OP_MARGIN_SET);
                                id_hv_ff      <= 1'b1;
                                state_ff      <= ST_MG_HV_UP;
                            end
                            default: begin
                                tmr_start_ff <= 1'b0;
                                fin_ff       <= 1'b1;
                                fin_fail_ff  <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_MG_HV_UP: begin
                    if (tmr_done) begin
                        supply_ff    <= 1'b1;
                        tmr_start_ff <= 1'b1;
                        tmr_load_ff  <= oepc_pkg::CYC_SETUP;
                        state_ff     <= ST_MG_SUPPLY_UP;
                    end
                end
                ST_MG_SUPPLY_UP: begin
                    if (tmr_done) begin
                        cs_n_ff      <= 1'b0;
                        tmr_start_ff <= 1'b1;
                        tmr_load_ff  <= oepc_pkg::CYC_MARGIN_PW;
                        state_ff     <= ST_MG_PULSE;
                    end
                end
                ST_MG_PULSE: begin
                    if (tmr_done) begin
                        cs_n_ff      <= 1'b1;
                        tmr_start_ff <= 1'b1;
                        tmr_load_ff  <= oepc_pkg::CYC_SETUP;
                        state_ff     <= ST_MG_HOLD;
                    end
                end
                ST_MG_HOLD: begin
                    if (tmr_done) begin
                        supply_ff    <= 1'b0;
                        tmr_start_ff <= 1'b1;
                        tmr_load_ff  <= oepc_pkg::CYC_SETUP;
                        state_ff     <= ST_MG_SUPPLY_DOWN;
                    end
                end
                ST_MG_SUPPLY_DOWN: begin
                    if (tmr_done) begin
                        id_hv_ff     <= 1'b0;
                        tmr_start_ff <= 1'b1;
                        if (prog_pend_ff) begin
                            mem_addr_ff  <= addr_ff;
                            dout_ff      <= data_ff;
                            doe_ff       <= 1'b1;
                            supply_ff    <= 1'b1;
                            tmr_load_ff  <= oepc_pkg::CYC_SETUP;
                            state_ff     <= ST_PG_SETUP;
                        end else begin
                            tmr_load_ff <= oepc_pkg::CYC_TURN;
                            state_ff    <= ST_TURN;
                        end
                    end
                end
                ST_PG_SETUP: begin
                    if (tmr_done) begin
                        cs_n_ff      <= 1'b0;
                        pulses_ff    <= pulses_ff + 8'h01;
                        tmr_start_ff <= 1'b1;
                        tmr_load_ff  <= oepc_pkg::CYC_PULSE;
                        state_ff     <= ST_PG_PULSE;
                    end
                end
                ST_PG_PULSE: begin
                    if (tmr_done) begin
                        cs_n_ff      <= 1'b1;
                        tmr_start_ff <= 1'b1;
                        tmr_load_ff  <= oepc_pkg::CYC_SETUP;
                        state_ff     <= ST_PG_HOLD;
                    end
                end
                ST_PG_HOLD: begin
                    if (tmr_done) begin
                        supply_ff    <= 1'b0;
                        doe_ff       <= 1'b0;
                        tmr_start_ff <= 1'b1;
                        tmr_load_ff  <= oepc_pkg::CYC_SETUP;
                        state_ff     <= ST_VF_SETUP;
                    end
                end
                ST_VF_SETUP: begin
                    if (tmr_done) begin
                        cs_n_ff      <= 1'b0;
                        gate_n_ff    <= 1'b0;
                        tmr_start_ff <= 1'b1;
                        tmr_load_ff  <= oepc_pkg::CYC_DV;
                        state_ff     <= ST_VF_ACCESS;
                    end
                end
                ST_VF_ACCESS: begin
                    if (tmr_done) begin
                        rd_ff        <= MEM_DATA_PINS_I;
                        cs_n_ff      <= 1'b1;
                        gate_n_ff    <= 1'b1;
                        id_hv_ff     <= 1'b0;
                        retry_ff     <= 1'b0;
                        tmr_start_ff <= 1'b1;
                        tmr_load_ff  <= oepc_pkg::CYC_TURN;
                        state_ff     <= ST_TURN;
                        if (op_ff == oepc_pkg::OP_PROGRAM) begin
                            if (MEM_DATA_PINS_I == data_ff) begin
                                fin_fail_ff <= 1'b0;
                            end else if (unrepairable(MEM_DATA_PINS_I, data_ff)) begin
                                fin_fail_ff <= 1'b1;
                            end else if (pulses_ff >= oepc_pkg::MAX_PULSES) begin
                                fin_fail_ff <= 1'b1;
                            end else begin
                                retry_ff <= 1'b1;
                            end
                        end else if (op_ff == oepc_pkg::OP_READ) begin
                            fin_fail_ff <= (MEM_DATA_PINS_I != data_ff);
                        end else begin
                            fin_fail_ff <= 1'b0;
                        end
                    end
                end
                ST_TURN: begin
                    // The memory may still drive the bus for up to 130 ns after deselect
                    if (tmr_done) begin
                        if (retry_ff) begin
                            retry_ff     <= 1'b0;
                            dout_ff      <= data_ff;
                            doe_ff       <= 1'b1;
                            supply_ff    <= 1'b1;
                            tmr_start_ff <= 1'b1;
                            tmr_load_ff  <= oepc_pkg::CYC_SETUP;
                            state_ff     <= ST_PG_SETUP;
                        end else begin
                            if (op_ff == oepc_pkg::OP_MARGIN_SET || op_ff == oepc_pkg::OP_MARGIN_CLEAR) begin
                                fin_fail_ff <= 1'b0;
                            end
                            fin_ff   <= 1'b1;
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Margin state mirrors what the memory latched on the last select rise
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            margin_ff <= 1'b0;
        end else if (state_ff == ST_MG_HOLD && tmr_done) begin
            margin_ff <= margin_tgt_ff;
        end
    end

    // Command acceptance; cleared on take so a held valid is not taken twice
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ready_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && CMD_VALID_I && ready_ff) begin
            ready_ff <= 1'b0;
        end else if (state_ff == ST_IDLE) begin
            ready_ff <= 1'b1;
        end else begin
            ready_ff <= 1'b0;
        end
    end

    // Answer: one-cycle valid, data and status stand until the next answer
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff  <= oepc_pkg::DATA_RST;
            rsp_fail_ff  <= 1'b0;
        end else begin
            rsp_valid_ff <= fin_ff;
            if (fin_ff) begin
                rsp_data_ff <= rd_ff;
                rsp_fail_ff <= fin_fail_ff;
            end
        end
    end

    assign CMD_READY_O              = ready_ff;
    assign RSP_VALID_O              = rsp_valid_ff;
    assign RSP_DATA_O               = rsp_data_ff;
    assign RSP_FAIL_O               = rsp_fail_ff;
    assign RSP_PULSES_O             = pulses_ff;
    assign MARGIN_ACTIVE_O          = margin_ff;
    assign MEM_ADDR_O               = mem_addr_ff;
    assign MEM_ID_HIGH_VOLTAGE_EN_O = id_hv_ff;
    assign MEM_CHIP_SEL_N_O         = cs_n_ff;
    assign MEM_OUTPUT_GATE_N_O      = gate_n_ff;
    assign MEM_PROGRAM_SUPPLY_EN_O  = supply_ff;
    assign MEM_DATA_PINS_O          = dout_ff;
    assign MEM_DATA_PINS_OE_O       = doe_ff;

endmodule : oepc_ctrl

// [testbench/oepc_ctrl_sva.sv]
// Checker of pin order and timing on the memory side of the programmer
`timescale 1ns/10ps
module oepc_ctrl_sva (
    input wire logic                        MCLK_I,
    input wire logic                        RESET_N_I,
    input wire logic [oepc_pkg::ADDR_W-1:0] MEM_ADDR_O,
    input wire logic                        MEM_ID_HIGH_VOLTAGE_EN_O,
    input wire logic                        MEM_CHIP_SEL_N_O,
    input wire logic                        MEM_OUTPUT_GATE_N_O,
    input wire logic                        MEM_PROGRAM_SUPPLY_EN_O,
    input wire logic                        MEM_DATA_PINS_OE_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RESET_N_I);
    // Counts low cycles of chip select, far past what an unrolled repetition could hold
    logic [11:0] low_cnt_ff;
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) low_cnt_ff <= 12'h000;
        else low_cnt_ff <= MEM_CHIP_SEL_N_O ? 12'h000 : low_cnt_ff + 12'h001;
    end
    a_pulse_width: assert property ($rose(MEM_CHIP_SEL_N_O) && MEM_DATA_PINS_OE_O |->
        low_cnt_ff inside {[12'h947:12'hA41]}) else $error("Program pulse width out of range");
    a_supply_setup: assert property ($fell(MEM_CHIP_SEL_N_O) && MEM_PROGRAM_SUPPLY_EN_O |->
        $past(MEM_PROGRAM_SUPPLY_EN_O, 50)) else $error("Supply raised too late before select");
    a_verify_supply_off: assert property ($fell(MEM_CHIP_SEL_N_O) && !MEM_PROGRAM_SUPPLY_EN_O |->
        !$past(MEM_PROGRAM_SUPPLY_EN_O, 50)) else $error("Supply removed too late before verify");
    a_addr_setup: assert property ($fell(MEM_CHIP_SEL_N_O) |->
        MEM_ADDR_O == $past(MEM_ADDR_O, 50)) else $error("Address not stable before select");
    a_data_hold: assert property ($fell(MEM_DATA_PINS_OE_O) |->
        $past(MEM_CHIP_SEL_N_O, 50)) else $error("Data released too soon after select");
    a_margin_entry: assert property ($rose(MEM_PROGRAM_SUPPLY_EN_O) && MEM_ID_HIGH_VOLTAGE_EN_O |->
        $past(MEM_ID_HIGH_VOLTAGE_EN_O, 50)) else $error("High voltage line late before supply");
    a_margin_exit: assert property ($fell(MEM_ID_HIGH_VOLTAGE_EN_O) |->
        !$past(MEM_PROGRAM_SUPPLY_EN_O, 50)) else $error("High voltage line dropped too early");
    a_no_contention: assert property (!MEM_CHIP_SEL_N_O && !MEM_OUTPUT_GATE_N_O |->
        !MEM_DATA_PINS_OE_O && !MEM_PROGRAM_SUPPLY_EN_O) else $error("Driving while memory outputs");
endmodule : oepc_ctrl_sva
bind oepc_ctrl oepc_ctrl_sva sva_i (.*);

// [testbench/oepc_mem_model.sv]
// Behavioural model of the one-time-programmable memory behind the pins
`timescale 1ns/10ps
module oepc_mem_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] PART_CODE  = 8'hC3  // Arbitrary value
) (
    input  wire logic [15:0] addr_i,
    input  wire logic        id_hv_i,
    input  wire logic        cs_n_i,
    input  wire logic        gate_n_i,
    input  wire logic        supply_i,
    input  wire logic [7:0]  data_i,
    output logic      [7:0]  data_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    logic       margin = 1'h0;
    int         need = 1; // Pulses before cells hold, raised to model a slow byte
    int         hits = 0;
    wire        drive = !cs_n_i && !gate_n_i && !supply_i;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    always @(posedge cs_n_i) begin
        if (supply_i && id_hv_i) begin
            margin = addr_i[10];
        end else if (supply_i) begin
            hits = hits + 1;
            if (hits >= need) mem[addr_i] = mem[addr_i] & data_i;
        end
    end
    always @* begin
        if (drive) last = id_hv_i ? (addr_i[0] ? PART_CODE : MAKER_CODE) : mem[addr_i];
    end
    // Released pins show the inverse so a stale value never passes
    assign data_o = drive ? last : ~last;
endmodule : oepc_mem_model

// [testbench/tb_top.sv]
// Self-checking bench for the memory programmer against the memory model
`timescale 1ns/10ps
module tb_top;
    localparam logic [7:0] MAKER_ID = 8'h5A; // Arbitrary value
    localparam logic [7:0] PART_ID  = 8'hC3; // Arbitrary value
    typedef struct {logic [2:0] op; logic [15:0] a; logic [7:0] d; logic [7:0] ed; logic ef; logic em;} oepc_row_s;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        cmd_valid = 1'h0;
    logic [2:0]  cmd_op = 3'h0;
    logic [15:0] cmd_addr = 16'h0000;
    logic [7:0]  cmd_data = 8'h00;
    logic [7:0]  rsp_data, rsp_pulses, din, dout;
    logic [15:0] mem_addr;
    logic        cmd_ready, rsp_valid, rsp_fail, margin, id_hv, cs_n, gate_n, supply, oe;
    wire  [7:0]  bus = oe ? dout : din;
    int          error_cnt = 0;
    int          num_checks = 0;
    oepc_row_s   rows [11];
    always #20 clk = ~clk;
    oepc_ctrl uut (.MCLK_I(clk), .RESET_N_I(rst_n), .CMD_VALID_I(cmd_valid), .CMD_OP_I(cmd_op),
        .CMD_ADDR_I(cmd_addr), .CMD_DATA_I(cmd_data), .CMD_READY_O(cmd_ready), .RSP_VALID_O(rsp_valid),
        .RSP_DATA_O(rsp_data), .RSP_FAIL_O(rsp_fail), .RSP_PULSES_O(rsp_pulses), .MARGIN_ACTIVE_O(margin),
        .MEM_ADDR_O(mem_addr), .MEM_ID_HIGH_VOLTAGE_EN_O(id_hv), .MEM_CHIP_SEL_N_O(cs_n),
        .MEM_OUTPUT_GATE_N_O(gate_n), .MEM_PROGRAM_SUPPLY_EN_O(supply), .MEM_DATA_PINS_I(bus),
        .MEM_DATA_PINS_O(dout), .MEM_DATA_PINS_OE_O(oe));
    oepc_mem_model #(.MAKER_CODE(MAKER_ID), .PART_CODE(PART_ID)) mem_i (.addr_i(mem_addr), .id_hv_i(id_hv),
        .cs_n_i(cs_n), .gate_n_i(gate_n), .supply_i(supply), .data_i(bus), .data_o(din));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic run_cmd(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'h1) @(posedge clk) #1;
        cmd_valid = 1'h1;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        @(posedge clk) #1;
        cmd_valid = 1'h0;
        while (rsp_valid !== 1'h1 && n < 80000) begin
            @(posedge clk) #1;
            n++;
        end
        if (n >= 80000) begin
            error_cnt++;
            print_verdict();
        end
    endtask : run_cmd
    initial begin
        #(100000 * 40);
        error_cnt++;
        print_verdict();
    end
    initial begin
        rows = '{'{3'h2, 16'h0000, 8'h00, MAKER_ID, 1'h0, 1'h0}, '{3'h2, 16'h0001, 8'h00, PART_ID, 1'h0, 1'h0},
                 '{3'h3, 16'h0000, 8'h00, 8'h00, 1'h0, 1'h1}, '{3'h1, 16'h1234, 8'hA5, 8'hA5, 1'h0, 1'h1},
                 '{3'h0, 16'h1234, 8'hA5, 8'hA5, 1'h0, 1'h1}, '{3'h0, 16'h1234, 8'h00, 8'hA5, 1'h1, 1'h1},
                 '{3'h0, 16'hFFFF, 8'hFF, 8'hFF, 1'h0, 1'h1}, '{3'h4, 16'h0000, 8'h00, 8'h00, 1'h0, 1'h0},
                 '{3'h5, 16'h0000, 8'h00, 8'h00, 1'h1, 1'h0}, '{3'h6, 16'h0000, 8'h00, 8'h00, 1'h1, 1'h0},
                 '{3'h7, 16'h0000, 8'h00, 8'h00, 1'h1, 1'h0}};
        repeat (16) @(posedge clk);
        check({cs_n, gate_n, supply, oe, id_hv, cmd_ready}, 24'h000030);
        #1 rst_n = 1'h1;
        $display("Reset test done");
        foreach (rows[i]) begin
            run_cmd(rows[i].op, rows[i].a, rows[i].d);
            check({rsp_fail, margin}, {rows[i].ef, rows[i].em});
            if (rows[i].op <= 3'h2) check(rsp_data, rows[i].ed);
            $display("Row %0d done", i);
        end
        mem_i.need = 3;
        mem_i.hits = 0;
        run_cmd(3'h1, 16'h0400, 8'h3C);
        check({rsp_fail, margin, rsp_pulses, rsp_data}, {2'h1, 8'h03, 8'h3C});
        check({mem_i.margin, mem_i.mem[16'h0400], 8'(mem_i.hits)}, {1'h1, 8'h3C, 8'h03});
        $display("Slow byte test done");
        mem_i.need = 1;
        run_cmd(3'h1, 16'h1234, 8'hFF);
        check({rsp_fail, rsp_pulses, mem_i.mem[16'h1234]}, {1'h1, 8'h01, 8'hA5});
        $display("Zero to one test done");
        mem_i.need = 99;
        mem_i.hits = 0;
        run_cmd(3'h1, 16'h2000, 8'h0F);
        check({rsp_fail, rsp_pulses, rsp_data}, {1'h1, oepc_pkg::MAX_PULSES, 8'hFF});
        $display("Pulse limit test done");
        // Reset with the program supply and high-voltage line up must drop every pin to idle
        cmd_valid = 1'h1;
        cmd_op = 3'h3;
        @(posedge clk) #1 cmd_valid = 1'h0;
        repeat (60) @(posedge clk);
        #1 rst_n = 1'h0;
        @(posedge clk) #1;
        check({cs_n, gate_n, supply, oe, id_hv, cmd_ready, margin}, 24'h000060);
        @(posedge clk) #1 rst_n = 1'h1;
        run_cmd(3'h2, 16'h0001, 8'h00);
        check({rsp_fail, rsp_data}, {1'h0, PART_ID});
        $display("Mid-run reset test done");
        print_verdict();
    end
endmodule : tb_top
